// ---- logic/sadc_pkg.sv ----
package sadc_pkg;
	// Result width and conversion-period counter width
	localparam int RES_W         = 8;
	localparam int CNT_W         = 6;
	// Conversion length in internal clock periods
	localparam int CONV_PERIODS  = 36;
	localparam int CONV_MAX_NS   = 17000;
	localparam int SYS_PERIOD_NS = 10;
	// Internal system clock divide: 100 MHz down to about 4 MHz
	localparam int SYS_DIV       = 25;
	localparam int DIV_W         = 5;
	// Falling edges of the transfer clock per transfer
	localparam logic [3:0] XFER_EDGES  = 4'h8;
	localparam logic [3:0] SAMPLE_EDGES = 4'h4;
	// Noise filter: internal rising edges, then one falling edge
	localparam logic [1:0] FILT_RISE = 2'h2;
	// Clamp codes for out-of-range input
	localparam logic [7:0] CODE_ALL_ONES  = 8'h00_FF;
	localparam logic [7:0] CODE_ALL_ZEROS = 8'h00_00;
	localparam logic [1:0] ZERO2 = 2'h0;
	localparam logic [3:0] ZERO4 = 4'h0;
	localparam logic [DIV_W-1:0] ZERO_DIV = 5'h00;
	localparam logic [CNT_W-1:0] ZERO_CNT = 6'h00;
	// Conversion state machine
	typedef enum logic [1:0] {
		SADC_IDLE = 2'b00,
		SADC_CONV = 2'b01
	} sadc_state_t;
endpackage : sadc_pkg

// ---- logic/sadc_core.sv ----
// Notes on behaviour
// - A conversion takes 36 internal clock periods, well inside 17 us.
// - A conversion starts on the eighth transfer-clock falling edge after select fell.
// - The result MSB appears on the output within three system clocks after select goes low.
// - The other seven bits shift out, MSB downward, on the first seven falling edges.
// - A finished result is read out in the next select-low transfer in the same way.
// - Conversion timing comes from an internal clock of about 4 MHz, free of the link.
// - Only select and transfer clock control transfer; the output is three-state.
// - Sampling follows the host's select and clock timing.
// - Each conversion yields 8 unsigned bits by successive approximation, MSB first.
// - After select falls, control inputs are ignored until the internal filter passes.
// - Sampling spans at most four transfer-clock cycles ahead of the conversion.
// - Inputs above or below the references clamp to all ones or all zeros.
module sadc_core
	import sadc_pkg::*;
#(
	parameter int CONV_LEN = CONV_PERIODS
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             xfer_clk,
	input  wire logic             sel_n,
	input  wire logic             cmp_above,
	input  wire logic             ain_over,
	input  wire logic             ain_under,
	output logic                  dout,
	output logic                  dout_oe,
	output logic                  sample_hold,
	output logic [RES_W-1:0]      dac_code,
	output logic                  busy
);
	// Counter end points
	localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_LEN - 1);
	localparam logic [DIV_W-1:0] DIV_LAST  = DIV_W'(SYS_DIV - 1);
	localparam logic [DIV_W-1:0] DIV_HALF  = DIV_W'(SYS_DIV / 2);
	localparam logic [2:0]       STEP_HI   = 3'(RES_W - 1);

	// ---------------- Link domain (transfer clock) ----------------
	logic [RES_W-1:0] shift_reg;
	logic [3:0]       edge_cnt_reg;
	logic             start_req_reg;
	logic             samp_win_reg;
	logic             dout_reg;
	logic             filt_done_reg;
	logic [RES_W-1:0] result_reg;

	// Filter release read as a level: it settles while the host waits out its
	// select setup, long before the first edge, and the link clock stands still
	// whenever it moves; a two-flop chain here would swallow the first edges
	wire link_rdy = filt_done_reg;

	// Falling edges counted once the filter has released; none while select is high
	always_ff @(negedge xfer_clk or posedge sel_n) begin
		if (sel_n) begin
			edge_cnt_reg <= ZERO4;
		end else if (link_rdy && edge_cnt_reg != XFER_EDGES) begin
			edge_cnt_reg <= edge_cnt_reg + 4'h1;
		end
	end

	// Start flag: raised by the eighth edge, dropped when select returns high
	wire last_edge = link_rdy && edge_cnt_reg == XFER_EDGES - 4'h1;
	always_ff @(negedge xfer_clk or posedge sel_n) begin
		if (sel_n) begin
			start_req_reg <= 1'b0;
		end else if (last_edge) begin
			start_req_reg <= 1'b1;
		end
	end

	// Sampling window opens on the fourth edge; the start flag closes it
	wire samp_edge = link_rdy && edge_cnt_reg == SAMPLE_EDGES - 4'h1;
	always_ff @(negedge xfer_clk or posedge sel_n) begin
		if (sel_n) begin
			samp_win_reg <= 1'b0;
		end else if (samp_edge) begin
			samp_win_reg <= 1'b1;
		end
	end

	// Data path: first counted edge loads the bits below the MSB, later edges
	// shift; the result only changes while select is high, so it is stable here
	wire shift_en = link_rdy && edge_cnt_reg < XFER_EDGES - 4'h1;
	always_ff @(negedge xfer_clk) begin
		if (edge_cnt_reg == ZERO4) begin
			shift_reg <= {result_reg[RES_W-2:0], 1'b0};
		end else if (shift_en) begin
			shift_reg <= {shift_reg[RES_W-2:0], 1'b0};
		end
	end
	wire dout_pin = (edge_cnt_reg == ZERO4) ? result_reg[RES_W-1] : shift_reg[RES_W-1];
	always_comb dout_reg = dout_pin;

	// ---------------- System clock domain ----------------
	sadc_state_t      state_reg, state_next;
	logic [DIV_W-1:0] div_reg;
	logic [CNT_W-1:0] per_reg;
	logic [2:0]       step_reg;
	logic [RES_W-1:0] sar_reg;
	logic             s1_reg, s2_reg, s3_reg;
	logic             sel1_reg, sel2_reg;
	logic [1:0]       rise_cnt_reg;
	logic             busy_reg, sh_reg, oe_reg, out_reg;
	logic             o1_reg, o2_reg, w1_reg, w2_reg;

	// Internal about-4 MHz tick derived from the system clock
	wire sys_rise = div_reg == ZERO_DIV;
	wire sys_fall = div_reg == DIV_HALF;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			div_reg <= ZERO_DIV;
		end else begin
			div_reg <= (div_reg == DIV_LAST) ? ZERO_DIV : div_reg + 5'h01;
		end
	end

	// Synchronise select, start flag, sample window and output bit into clk
	always_ff @(posedge clk) begin
		if (!nrst) begin
			{sel1_reg, sel2_reg, s1_reg, s2_reg, s3_reg} <= 5'h18;
			{o1_reg, o2_reg, w1_reg, w2_reg} <= 4'h0;
		end else begin
			{sel1_reg, sel2_reg} <= {sel_n, sel1_reg};
			{s1_reg, s2_reg, s3_reg} <= {start_req_reg, s1_reg, s2_reg};
			{o1_reg, o2_reg} <= {dout_reg, o1_reg};
			{w1_reg, w2_reg} <= {samp_win_reg, w1_reg};
		end
	end
	wire start_evt = s2_reg && !s3_reg;
	wire samp_win  = w2_reg && !s2_reg;

	// Noise filter: two internal rises then one fall after select drops
	always_ff @(posedge clk) begin
		if (!nrst || sel2_reg) begin
			rise_cnt_reg  <= ZERO2;
			filt_done_reg <= 1'b0;
		end else if (sys_rise && rise_cnt_reg != FILT_RISE) begin
			rise_cnt_reg <= rise_cnt_reg + 2'h1;
		end else if (sys_fall && rise_cnt_reg == FILT_RISE) begin
			filt_done_reg <= 1'b1;
		end
	end

	// Conversion sequencer
	wire conv_last = sys_rise && per_reg == CONV_LAST;
	wire step_tick = sys_rise && per_reg[1:0] == 2'h3 && step_reg != 3'h0;
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			SADC_IDLE: if (start_evt) state_next = SADC_CONV;
			SADC_CONV: if (conv_last) state_next = SADC_IDLE;
		endcase
	end

	// SAR step: keep the trial bit when the comparator says the input is above
	wire [RES_W-1:0] kept  = cmp_above ? sar_reg : (sar_reg & ~(8'h01 << step_reg));
	wire [RES_W-1:0] final_code = ain_over ? CODE_ALL_ONES :
		(ain_under ? CODE_ALL_ZEROS : kept);
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_reg <= SADC_IDLE;
			per_reg   <= ZERO_CNT;
			step_reg  <= STEP_HI;
			sar_reg   <= CODE_ALL_ZEROS;
			result_reg <= CODE_ALL_ZEROS;
		end else begin
			state_reg <= state_next;
			if (state_reg == SADC_IDLE && start_evt) begin
				per_reg  <= ZERO_CNT;
				step_reg <= STEP_HI;
				sar_reg  <= 8'h00_80;
			end else if (state_reg == SADC_CONV && sys_rise) begin
				per_reg <= per_reg + 6'h01;
				if (step_tick) begin
					sar_reg  <= (kept | (8'h01 << (step_reg - 3'h1)));
					step_reg <= step_reg - 3'h1;
				end
				if (conv_last) begin
					result_reg <= final_code;
				end
			end
		end
	end

	// Registered outputs: sample window, output enable, busy, serial pin
	always_ff @(posedge clk) begin
		if (!nrst) begin
			{busy_reg, sh_reg, oe_reg, out_reg} <= 4'h0;
		end else begin
			busy_reg <= state_next == SADC_CONV;
			sh_reg   <= samp_win && state_reg == SADC_IDLE;
			oe_reg   <= !sel2_reg;
			out_reg  <= o2_reg;
		end
	end
	assign busy        = busy_reg;
	assign sample_hold = sh_reg;
	assign dout_oe     = oe_reg;
	assign dout        = out_reg;
	assign dac_code    = sar_reg;
endmodule : sadc_core

// ---- tb/sadc_core_assertions.sv ----
module sadc_core_assertions
	import sadc_pkg::*;
#(
	parameter int CONV_LEN = CONV_PERIODS
) (
	input wire logic             clk,
	input wire logic             nrst,
	input wire logic             xfer_clk,
	input wire logic             sel_n,
	input wire logic             cmp_above,
	input wire logic             ain_over,
	input wire logic             ain_under,
	input wire logic             dout,
	input wire logic             dout_oe,
	input wire logic             sample_hold,
	input wire logic [RES_W-1:0] dac_code,
	input wire logic             busy
);
	timeunit 1ns;
	timeprecision 1ps;
	// The start lands anywhere in an internal period, so the first one is partial
	localparam int BUSY_LO = (CONV_LEN - 1) * SYS_DIV + 1;
	localparam int BUSY_HI = CONV_LEN * SYS_DIV;
	logic [3:0]  ecnt;
	logic [10:0] bcnt;
	logic        xq;
	wire         fall = xq & ~xfer_clk & ~sel_n;
	// Count falling edges within a transfer and the cycles busy stands
	always_ff @(posedge clk) begin
		xq   <= xfer_clk;
		ecnt <= (!nrst || sel_n) ? 4'h0 : ecnt + {3'h0, fall};
		bcnt <= (!nrst || !busy) ? 11'h000 : bcnt + 11'h001;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence sel_idle; sel_n [*6]; endsequence
	sequence eighth; fall && ecnt == 4'h7; endsequence
	idle_float_a: assert property (sel_idle |-> !dout_oe)
		else $error("output driven while deselected");
	conv_len_a: assert property ($fell(busy) |-> bcnt >= BUSY_LO && bcnt <= BUSY_HI)
		else $error("conversion length wrong");
	start_edge_a: assert property ($rose(busy) |-> ecnt == 4'h8)
		else $error("conversion began off the eighth edge");
	start_soon_a: assert property (eighth |-> ##[1:30] busy)
		else $error("conversion did not begin");
	msb_out_a: assert property ($fell(sel_n) |-> ##[1:12] dout_oe)
		else $error("first bit not driven");
	bit_hold_a: assert property ($rose(xfer_clk) && !sel_n && ecnt != 4'h0 |=> $stable(dout) [*8])
		else $error("output moved between falling edges");
	sample_busy_a: assert property (sample_hold |-> !busy)
		else $error("sampling during conversion");
	sample_open_a: assert property (fall && ecnt == 4'h3 |-> ##[1:8] sample_hold)
		else $error("sampling did not open on the fourth edge");
	sample_win_a: assert property (sample_hold |-> ecnt >= 4'h4)
		else $error("sampling before the fourth edge");
	dac_busy_a: assert property ($changed(dac_code) |-> $past(busy) or ##[0:1] busy)
		else $error("trial code moved while idle");
endmodule : sadc_core_assertions
bind sadc_core sadc_core_assertions #(.CONV_LEN(CONV_LEN)) u_chk (.clk, .nrst, .xfer_clk,
	.sel_n, .cmp_above, .ain_over, .ain_under, .dout, .dout_oe, .sample_hold, .dac_code, .busy);

// ---- tb/sadc_host_model.sv ----
module sadc_host_model (
	input  wire logic lclk,
	input  wire logic dout,
	input  wire logic dout_oe,
	output logic      sel_n,
	output logic      xfer_clk
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SETUP = 240;  // Select low 1.4 us before the first edge
	localparam int HALF  = 84;   // Transfer clock near 0.98 MHz
	localparam int HOLD  = 2850; // Select high 17 us after a start
	// A select pulse during reset clears the link logic, which has no other reset
	initial begin
		sel_n = 1'b0;
		xfer_clk = 1'b0;
		@(posedge lclk) sel_n <= 1'b1;
	end
	// One clock pulse; the clock stands low between pulses
	task automatic pulse;
		@(posedge lclk) xfer_clk <= 1'b1;
		repeat (HALF) @(posedge lclk);
		@(posedge lclk) xfer_clk <= 1'b0;
		repeat (HALF) @(posedge lclk);
	endtask : pulse
	// Read eight bits MSB first; the eighth edge starts a conversion
	task automatic xfer(output logic [7:0] got);
		@(posedge lclk) sel_n <= 1'b0;
		repeat (SETUP) @(posedge lclk);
		for (int i = 7; i >= 0; i--) begin
			got[i] = dout_oe ? dout : 1'bz;
			pulse();
		end
		@(posedge lclk) sel_n <= 1'b1;
		repeat (HOLD) @(posedge lclk);
	endtask : xfer
endmodule : sadc_host_model

// ---- tb/serial_adc_transfer_control_test.sv ----
module serial_adc_transfer_control_test
	import sadc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic             clk = 1'b0, lclk = 1'b0, nrst = 1'b0;
	logic             cmp_above, ain_over = 1'b0, ain_under = 1'b0;
	logic [RES_W-1:0] ain_val = 8'h00, dac_code, got;
	logic             dout, dout_oe, sample_hold, busy, sel_n, xfer_clk;
	int               n_errors = 0, compares = 0;
	always #5 clk = ~clk;
	always #3 lclk = ~lclk;
	// Comparator model: keep the trial bit while the input is not below it
	always_ff @(posedge clk) cmp_above <= ain_val >= dac_code;
	sadc_core u_sadc_core (.clk, .nrst, .xfer_clk, .sel_n, .cmp_above, .ain_over,
		.ain_under, .dout, .dout_oe, .sample_hold, .dac_code, .busy);
	sadc_host_model u_sadc_host_model (.lclk, .dout, .dout_oe, .sel_n, .xfer_clk);
	task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : check_byte
	task automatic give_verdict;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	// Each transfer returns the result of the one before
	task automatic test_back_to_back;
		@(posedge clk) ain_val <= 8'h5A;
		u_sadc_host_model.xfer(got);
		@(posedge clk) ain_val <= 8'hA5;
		u_sadc_host_model.xfer(got);
		check_byte(got, 8'h5A);
		u_sadc_host_model.xfer(got);
		check_byte(got, 8'hA5);
	endtask : test_back_to_back
	// Out-of-range inputs clamp; stray edges while deselected do nothing
	task automatic test_clamp;
		@(posedge clk) ain_over <= 1'b1;
		u_sadc_host_model.xfer(got);
		check_byte(got, 8'hA5);
		@(posedge clk) {ain_over, ain_under} <= 2'h1;
		repeat (8) u_sadc_host_model.pulse();
		check_byte({7'h00, dout_oe}, 8'h00);
		u_sadc_host_model.xfer(got);
		check_byte(got, 8'hFF);
		@(posedge clk) ain_under <= 1'b0;
		u_sadc_host_model.xfer(got);
		check_byte(got, 8'h00);
	endtask : test_clamp
	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		test_back_to_back();
		test_clamp();
		give_verdict();
	end
	// Watchdog against a hung transfer
	initial begin
		repeat (40000) @(posedge clk);
		n_errors++;
		give_verdict();
	end
endmodule : serial_adc_transfer_control_test
